/* File: hdl/haptic_loop_timing_config.sv */
// Summary of operation
// - clamp code 0 unclamped; 1..3 give 25/50/100 ms
// - after clamp time, limit output to rated clamp
// - clamp at expiry, not at a zero crossing
// - autocal and diagnostics ignore the clamp selector
// - sample delay codes 150..300 us, reset code 3
// - window codes 100/200/300/390 us, reset code 0
`timescale 1ns/10ps
`default_nettype none

module haptic_loop_timing_config
	import loop_timing_pkg::*;
#(
	parameter int CLAMP1_CYCLES  = loop_timing_pkg::CLAMP1_CYC,
	parameter int CLAMP2_CYCLES  = loop_timing_pkg::CLAMP2_CYC,
	parameter int CLAMP3_CYCLES  = loop_timing_pkg::CLAMP3_CYC,
	parameter int SAMPLE1_CYCLES = loop_timing_pkg::SAMPLE1_CYC,
	parameter int SAMPLE2_CYCLES = loop_timing_pkg::SAMPLE2_CYC,
	parameter int SAMPLE3_CYCLES = loop_timing_pkg::SAMPLE3_CYC,
	parameter int WINDOW1_CYCLES = loop_timing_pkg::WINDOW1_CYC,
	parameter int WINDOW2_CYCLES = loop_timing_pkg::WINDOW2_CYC,
	parameter int WINDOW3_CYCLES = loop_timing_pkg::WINDOW3_CYC
)
(
	input  wire logic                                 i_sys_clk,
	input  wire logic                                 i_rst_n,
	input  wire logic                                 i_awvalid,
	output logic                                      o_awready,
	input  wire logic [loop_timing_pkg::AXI_ADDR_W-1:0] i_awaddr,
	input  wire logic                                 i_wvalid,
	output logic                                      o_wready,
	input  wire logic [31:0]                          i_wdata,
	input  wire logic [3:0]                           i_wstrb,
	output logic                                      o_bvalid,
	input  wire logic                                 i_bready,
	output logic [1:0]                                o_bresp,
	input  wire logic                                 i_arvalid,
	output logic                                      o_arready,
	input  wire logic [loop_timing_pkg::AXI_ADDR_W-1:0] i_araddr,
	output logic                                      o_rvalid,
	input  wire logic                                 i_rready,
	output logic [31:0]                               o_rdata,
	output logic [1:0]                                o_rresp,
	input  wire logic                                 i_overdrive_active,
	input  wire logic                                 i_autocal_active,
	input  wire logic                                 i_diag_active,
	output loop_timing_pkg::timing_s                  o_timing,
	output logic                                      o_clamp_to_rated
);
	import loop_timing_pkg::*;

	// ---------------------------------------------------------------
	// bus slave state
	// ---------------------------------------------------------------
	loop_timing_s          ctrl, next_ctrl;
	logic                  aw_held, next_aw_held;
	logic [AXI_ADDR_W-1:0] aw_addr, next_aw_addr;
	logic                  w_held, next_w_held;
	logic [7:0]            w_byte, next_w_byte;
	logic                  w_lane0, next_w_lane0;
	logic                  bvalid, next_bvalid;
	logic [1:0]            bresp, next_bresp;
	logic                  rvalid, next_rvalid;
	logic [31:0]           rdata, next_rdata;
	logic [1:0]            rresp, next_rresp;
	logic                  do_write;

	// word index decode shared by both address channels
	function automatic logic reg_hit(input logic [AXI_ADDR_W-1:0] addr);
		return addr[AXI_ADDR_W-1:2] == LOOP_TIMING_IDX;
	endfunction

	// no new address or data while a response is pending
	assign o_awready = !aw_held && !bvalid;
	assign o_wready  = !w_held && !bvalid;
	assign o_arready = !rvalid;
	assign do_write  = aw_held && w_held && !bvalid;

	// address and data may arrive in either order
	always_comb
	begin
		next_ctrl    = ctrl;
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held  = w_held;
		next_w_byte  = w_byte;
		next_w_lane0 = w_lane0;
		next_bvalid  = bvalid;
		next_bresp   = bresp;
		next_rvalid  = rvalid;
		next_rdata   = rdata;
		next_rresp   = rresp;
		if (i_awvalid && o_awready)
		begin
			next_aw_held = 1'b1;
			next_aw_addr = i_awaddr;
		end
		if (i_wvalid && o_wready)
		begin
			next_w_held  = 1'b1;
			next_w_byte  = i_wdata[7:0];
			next_w_lane0 = i_wstrb[0];
		end
		if (do_write)
		begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = reg_hit(aw_addr) ? RESP_OKAY : RESP_SLVERR;
			if (reg_hit(aw_addr) && w_lane0)
				next_ctrl = w_byte;
		end
		else if (bvalid && i_bready)
			next_bvalid = 1'b0;
		if (i_arvalid && o_arready)
		begin
			next_rvalid = 1'b1;
			next_rdata  = reg_hit(i_araddr) ? {24'h000000, ctrl} : 32'h00000000;
			next_rresp  = reg_hit(i_araddr) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rvalid && i_rready)
			next_rvalid = 1'b0;
	end

	// reset loads the documented field defaults
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			ctrl    <= LOOP_TIMING_RESET;
			aw_held <= 1'b0;
			aw_addr <= '0;
			w_held  <= 1'b0;
			w_byte  <= 8'h00;
			w_lane0 <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
			rvalid  <= 1'b0;
			rdata   <= 32'h00000000;
			rresp   <= RESP_OKAY;
		end
		else
		begin
			ctrl    <= next_ctrl;
			aw_held <= next_aw_held;
			aw_addr <= next_aw_addr;
			w_held  <= next_w_held;
			w_byte  <= next_w_byte;
			w_lane0 <= next_w_lane0;
			bvalid  <= next_bvalid;
			bresp   <= next_bresp;
			rvalid  <= next_rvalid;
			rdata   <= next_rdata;
			rresp   <= next_rresp;
		end
	end

	assign o_bvalid = bvalid;
	assign o_bresp  = bresp;
	assign o_rvalid = rvalid;
	assign o_rdata  = rdata;
	assign o_rresp  = rresp;

	// ---------------------------------------------------------------
	// field decode and overdrive clamp timer
	// ---------------------------------------------------------------
	timing_s          timing, next_timing;
	logic [CNT_W-1:0] od_count, next_od_count;
	logic             clamp_out, next_clamp_out;
	logic             clamp_allowed;

	// calibration and diagnostics always run unclamped
	assign clamp_allowed = timing.clamp_enabled && !i_autocal_active
		&& !i_diag_active;

	// decode is registered so the drive logic sees flop outputs
	always_comb
	begin
		next_timing.clamp_enabled = ctrl.overdrive_clamp_select != 2'h0;
		unique case (ctrl.overdrive_clamp_select)
			2'h1: next_timing.clamp_cycles = CNT_W'(CLAMP1_CYCLES);
			2'h2: next_timing.clamp_cycles = CNT_W'(CLAMP2_CYCLES);
			2'h3: next_timing.clamp_cycles = CNT_W'(CLAMP3_CYCLES);
			2'h0: next_timing.clamp_cycles = '0;
		endcase
		unique case (ctrl.sample_delay)
			2'h0: next_timing.sample_cycles = CNT_W'(SAMPLE0_CYC);
			2'h1: next_timing.sample_cycles = CNT_W'(SAMPLE1_CYCLES);
			2'h2: next_timing.sample_cycles = CNT_W'(SAMPLE2_CYCLES);
			2'h3: next_timing.sample_cycles = CNT_W'(SAMPLE3_CYCLES);
		endcase
		unique case (ctrl.zero_cross_window)
			2'h0: next_timing.window_cycles = CNT_W'(WINDOW0_CYC);
			2'h1: next_timing.window_cycles = CNT_W'(WINDOW1_CYCLES);
			2'h2: next_timing.window_cycles = CNT_W'(WINDOW2_CYCLES);
			2'h3: next_timing.window_cycles = CNT_W'(WINDOW3_CYCLES);
		endcase
		// counter saturates so a long period cannot wrap and release
		if (!i_overdrive_active)
			next_od_count = '0;
		else if (od_count != {CNT_W{1'b1}})
			next_od_count = od_count + 1'b1;
		else
			next_od_count = od_count;
		// expiry alone triggers the clamp, no zero crossing wait
		// one extra bit so the saturated count cannot wrap to zero here
		next_clamp_out = i_overdrive_active && clamp_allowed
			&& ({1'b0, od_count} + 1'b1 >= {1'b0, timing.clamp_cycles});
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			timing    <= '0;
			od_count  <= '0;
			clamp_out <= 1'b0;
		end
		else
		begin
			timing    <= next_timing;
			od_count  <= next_od_count;
			clamp_out <= next_clamp_out;
		end
	end

	assign o_timing         = timing;
	assign o_clamp_to_rated = clamp_out;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	a_reset_fields:
	assert property (@(posedge i_sys_clk) !i_rst_n |=> ctrl == LOOP_TIMING_RESET)
	else $error("control register not at default after reset");

	a_code0_unclamped:
	assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		!timing.clamp_enabled |=> !clamp_out)
	else $error("clamp asserted with clamp code zero");

	a_clamp_length:
	assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		ctrl.overdrive_clamp_select == 2'h2 ##2 ctrl.overdrive_clamp_select == 2'h2
		|-> timing.clamp_cycles == CNT_W'(CLAMP2_CYCLES))
	else $error("clamp code 2 decodes to wrong length");

	a_clamp_on_expiry:
	assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_overdrive_active && clamp_allowed && od_count + 1'b1 == timing.clamp_cycles
		|=> clamp_out)
	else $error("clamp missing at expiry");

	a_no_early_clamp:
	assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		$rose(clamp_out) |-> $past(od_count) + 1'b1 >= $past(timing.clamp_cycles)
		&& $past(i_overdrive_active))
	else $error("clamp rose before the selected time");

	a_cal_ignores:
	assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_autocal_active || i_diag_active) |=> !clamp_out)
	else $error("clamp applied during calibration or diagnostics");

	a_sample_decode:
	assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		ctrl.sample_delay == 2'h0 |=> timing.sample_cycles == CNT_W'(SAMPLE0_CYC))
	else $error("sample delay code 0 decodes wrong");

	a_window_decode:
	assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		ctrl.zero_cross_window == 2'h3 |=> timing.window_cycles == CNT_W'(WINDOW3_CYCLES))
	else $error("window code 3 decodes wrong");

	a_write_lands:
	assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		do_write && reg_hit(aw_addr) && w_lane0 |=> ctrl == $past(w_byte) && bvalid)
	else $error("register write did not land");

endmodule

`default_nettype wire

/* File: hdl/loop_timing_pkg.sv */
package loop_timing_pkg;

	// ---------------------------------------------------------------
	// clock and counter widths
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int CNT_W         = 24;
	localparam int AXI_ADDR_W    = 12;

	// round a least time up to whole cycles, never below one
	function automatic int ns_to_cycles(input int t_ns);
		int c;
		c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	// ---------------------------------------------------------------
	// register map and layout
	// ---------------------------------------------------------------
	localparam logic [9:0] LOOP_TIMING_IDX   = 10'h029;
	localparam logic [7:0] LOOP_TIMING_RESET = 8'h0c;
	localparam int CLAMP_LSB  = 4;
	localparam int SAMPLE_LSB = 2;
	localparam int WINDOW_LSB = 0;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ---------------------------------------------------------------
	// documented times and their cycle counts
	// ---------------------------------------------------------------
	localparam int CLAMP1_MS  = 25;
	localparam int CLAMP2_MS  = 50;
	localparam int CLAMP3_MS  = 100;
	localparam int SAMPLE0_US = 150;
	localparam int SAMPLE1_US = 200;
	localparam int SAMPLE2_US = 250;
	localparam int SAMPLE3_US = 300;
	localparam int WINDOW0_US = 100;
	localparam int WINDOW1_US = 200;
	localparam int WINDOW2_US = 300;
	localparam int WINDOW3_US = 390;

	localparam int CLAMP1_CYC  = ns_to_cycles(CLAMP1_MS * 1000000);
	localparam int CLAMP2_CYC  = ns_to_cycles(CLAMP2_MS * 1000000);
	localparam int CLAMP3_CYC  = ns_to_cycles(CLAMP3_MS * 1000000);
	localparam int SAMPLE0_CYC = ns_to_cycles(SAMPLE0_US * 1000);
	localparam int SAMPLE1_CYC = ns_to_cycles(SAMPLE1_US * 1000);
	localparam int SAMPLE2_CYC = ns_to_cycles(SAMPLE2_US * 1000);
	localparam int SAMPLE3_CYC = ns_to_cycles(SAMPLE3_US * 1000);
	localparam int WINDOW0_CYC = ns_to_cycles(WINDOW0_US * 1000);
	localparam int WINDOW1_CYC = ns_to_cycles(WINDOW1_US * 1000);
	localparam int WINDOW2_CYC = ns_to_cycles(WINDOW2_US * 1000);
	localparam int WINDOW3_CYC = ns_to_cycles(WINDOW3_US * 1000);

	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [1:0] reserved;
		logic [1:0] overdrive_clamp_select;
		logic [1:0] sample_delay;
		logic [1:0] zero_cross_window;
	} loop_timing_s;

	typedef struct packed {
		logic             clamp_enabled;
		logic [CNT_W-1:0] clamp_cycles;
		logic [CNT_W-1:0] sample_cycles;
		logic [CNT_W-1:0] window_cycles;
	} timing_s;

endpackage

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	import loop_timing_pkg::*;

	// ---------------------------------------------------------------
	// signals and shortened counts
	// ---------------------------------------------------------------
	localparam int C1 = 20, C2 = 40, C3 = 80, S1 = 10, S2 = 20, S3 = 30;
	logic        sys_clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, clamp, od, autocal, diag;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	timing_s     timing;
	int          fails, num_checks;
	typedef struct {logic [7:0] d; logic en; int cl; int sa; int wi;} row_s;
	row_s        rows[5];

	haptic_loop_timing_config #(.CLAMP1_CYCLES(C1), .CLAMP2_CYCLES(C2), .CLAMP3_CYCLES(C3),
		.SAMPLE1_CYCLES(S1), .SAMPLE2_CYCLES(S2), .SAMPLE3_CYCLES(S3),
		.WINDOW1_CYCLES(S1), .WINDOW2_CYCLES(S2), .WINDOW3_CYCLES(S3))
	haptic_loop_timing_config_inst
	(
		.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_awvalid(awvalid), .o_awready(awready),
		.i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
		.i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
		.i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid),
		.i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .i_overdrive_active(od),
		.i_autocal_active(autocal), .i_diag_active(diag), .o_timing(timing),
		.o_clamp_to_rated(clamp)
	);

	// ---------------------------------------------------------------
	// compare, bus and verdict tasks
	// ---------------------------------------------------------------
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %0t value %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_flag(input logic got, input logic exp);
		num_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %0t flag %b expected %b", $time, got, exp);
		end
	endtask

	// called just after an edge; bready held up until the answer is seen
	// bready and rready stay high afterwards, so back-to-back calls never
	// lower and raise them in one time step
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		int n;
		awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
			n++;
		end while (bvalid !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			fails++;
			$display("[ERR] %0t no write response", $time);
		end
		chk_val({30'h0, bresp}, {30'h0, er});
	endtask

	task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
			n++;
		end while (rvalid !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			fails++;
			$display("[ERR] %0t no read response", $time);
		end
		chk_val(rdata, ed);
		chk_val({30'h0, rresp}, {30'h0, er});
	endtask

	// overdrive held high; n = 0 means the clamp must never come
	task automatic clamp_run(input logic [1:0] c, input logic ac, input logic dg, input int n);
		int k;
		axi_wr(12'h0a4, {26'h0, c, 4'hc}, 4'h1, RESP_OKAY);
		@(posedge sys_clk);
		autocal <= ac; diag <= dg; od <= 1'b1;
		for (k = 1; k <= 90; k++)
		begin
			@(posedge sys_clk);
			#1;
			if (k == n - 1) chk_flag(clamp, 1'b0);
			if (k == n || k == 90) chk_flag(clamp, n != 0);
		end
		// diagnostics mid-overdrive must drop the clamp at the next edge
		@(posedge sys_clk);
		diag <= 1'b1;
		@(posedge sys_clk);
		#1;
		chk_flag(clamp, 1'b0);
		@(posedge sys_clk);
		od <= 1'b0; autocal <= 1'b0; diag <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic finish_test;
		if (fails == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// clock, watchdog and test sequence
	// ---------------------------------------------------------------
	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// whole run is under a thousand cycles; twenty thousand is ample
	initial
	begin
		#(40 * 20000);
		fails++;
		finish_test();
	end

	initial
	begin
		rst_n = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
		rready = 1'b0; awaddr = 12'h0; araddr = 12'h0; wdata = 32'h0; wstrb = 4'h0;
		od = 1'b0; autocal = 1'b0; diag = 1'b0; fails = 0; num_checks = 0;
		rows[0] = '{8'h00, 1'b0, 0, SAMPLE0_CYC, WINDOW0_CYC};
		rows[1] = '{8'h15, 1'b1, C1, S1, S1};
		rows[2] = '{8'h2a, 1'b1, C2, S2, S2};
		rows[3] = '{8'h3f, 1'b1, C3, S3, S3};
		rows[4] = '{8'hc6, 1'b0, 0, S1, S2};
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		axi_rd(12'h0a4, 32'h0000000c, RESP_OKAY);
		chk_val({8'h00, timing.sample_cycles}, 32'(S3));
		chk_val({8'h00, timing.window_cycles}, 32'(WINDOW0_CYC));
		chk_flag(timing.clamp_enabled, 1'b0);
		foreach (rows[i])
		begin
			axi_wr(12'h0a4, {24'h0, rows[i].d}, 4'h1, RESP_OKAY);
			axi_rd(12'h0a4, {24'h0, rows[i].d}, RESP_OKAY);
			repeat (2) @(posedge sys_clk);
			chk_flag(timing.clamp_enabled, rows[i].en);
			if (rows[i].en) chk_val({8'h00, timing.clamp_cycles}, 32'(rows[i].cl));
			chk_val({8'h00, timing.sample_cycles}, 32'(rows[i].sa));
			chk_val({8'h00, timing.window_cycles}, 32'(rows[i].wi));
		end
		// masked byte and unmapped place leave the register alone
		axi_wr(12'h0a4, 32'h000000ff, 4'he, RESP_OKAY);
		axi_wr(12'h0a8, 32'h000000ff, 4'hf, RESP_SLVERR);
		axi_rd(12'h0a8, 32'h0, RESP_SLVERR);
		axi_rd(12'h0a4, 32'h000000c6, RESP_OKAY);
		clamp_run(2'h1, 1'b0, 1'b0, C1);
		clamp_run(2'h2, 1'b0, 1'b0, C2);
		clamp_run(2'h3, 1'b0, 1'b0, C3);
		clamp_run(2'h0, 1'b0, 1'b0, 0);
		clamp_run(2'h3, 1'b1, 1'b0, 0);
		clamp_run(2'h3, 1'b0, 1'b1, 0);
		// second reset in mid-run restores the defaults
		axi_wr(12'h0a4, 32'h000000ff, 4'h1, RESP_OKAY);
		rst_n <= 1'b0;
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		axi_rd(12'h0a4, 32'h0000000c, RESP_OKAY);
		finish_test();
	end

endmodule

`default_nettype wire
